// file: verilog/prot_pkg.sv
package prot_pkg;

  // Clock and derived timing
  localparam int unsigned CLK_HZ       = 50_000_000;  // Core clock rate
  localparam int unsigned MS_PER_SEC   = 1000;
  localparam int unsigned MS_CYC       = CLK_HZ / MS_PER_SEC;  // Cycles per millisecond
  localparam int unsigned WD_TIME_MS   = 100;         // Watchdog expiry time, ms
  localparam int unsigned WD_CYC       = WD_TIME_MS * MS_CYC;
  localparam logic [4:0]  RST_PULSE    = 5'h10;       // Restart pulse length, cycles

  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MASK   = 8'h08;
  localparam logic [7:0] A_STATE  = 8'h0c;
  localparam logic [7:0] A_OC_THR = 8'h10;
  localparam logic [7:0] A_OT_THR = 8'h14;
  localparam logic [7:0] A_DRT_C  = 8'h18;
  localparam logic [7:0] A_DRT_M  = 8'h1c;
  localparam logic [7:0] A_SPD_MX = 8'h20;
  localparam logic [7:0] A_SPD_BK = 8'h24;
  localparam logic [7:0] A_REGEN  = 8'h28;
  localparam logic [7:0] A_TOUT   = 8'h2c;
  localparam logic [7:0] A_IHEAD  = 8'h30;

  // Field positions
  localparam int unsigned B_LATCH_OC = 0;  // Control: latching over-current
  localparam int unsigned B_LATCH_OT = 1;  // Control: latching over-temperature
  localparam int unsigned B_OC       = 0;  // Status: over-current shutdown
  localparam int unsigned B_OT       = 1;  // Status: over-temperature shutdown
  localparam int unsigned B_TOUT     = 2;  // Status: command timeout
  localparam int unsigned B_WD       = 3;  // Status: watchdog restart

  // Reset values
  localparam logic [1:0]  R_CTRL   = 2'h0;      // Both non-latching
  localparam logic [3:0]  R_MASK   = 4'h0;
  localparam logic [15:0] R_OC_THR = 16'h0c00;
  localparam logic [15:0] R_OT_THR = 16'h0700;
  localparam logic [15:0] R_DRT_C  = 16'h0600;
  localparam logic [15:0] R_DRT_M  = 16'h0900;
  localparam logic [15:0] R_SPD_MX = 16'h1000;
  localparam logic [15:0] R_SPD_BK = 16'h1800;
  localparam logic [15:0] R_REGEN  = 16'h0e00;
  localparam logic [15:0] R_TOUT   = 16'h0064;  // 100 ms
  localparam logic [15:0] R_IHEAD  = 16'h0200;

  // Supervisor states
  typedef enum logic [4:0] {
    ST_OFF    = 5'h01,
    ST_RUN    = 5'h02,
    ST_DERATE = 5'h04,
    ST_FAULT  = 5'h08,
    ST_BRAKE  = 5'h10
  } sup_state_e;

endpackage

// file: verilog/volt_limiter.sv
`timescale 1ns/10ps
module volt_limiter
  import prot_pkg::*;
(
  // Demand and measurements
  input  wire logic [15:0] cmd_i,
  input  wire logic [15:0] speed_i,
  input  wire logic [15:0] ctrl_temp_i,
  input  wire logic [15:0] coil_temp_i,
  input  wire logic [15:0] bus_volt_i,
  // Limits
  input  wire logic [15:0] ihead_i,
  input  wire logic [15:0] drt_ctrl_i,
  input  wire logic [15:0] drt_coil_i,
  input  wire logic [15:0] spd_max_i,
  input  wire logic [15:0] regen_i,
  // Result
  output logic      [15:0] volt_o,
  output logic             derate_o
);

  // Saturating subtraction, never wraps below zero
  function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
    sub_sat = (a > b) ? a - b : 16'h0000;
  endfunction

  // Excess of a temperature over its derate start, scaled up
  function automatic logic [15:0] derate(input logic [15:0] t, input logic [15:0] s);
    logic [15:0] ex;
    ex     = sub_sat(t, s);
    // Saturate, so a large excess never wraps round to a small cut
    derate = (ex > 16'h3fff) ? 16'hffff : {ex[13:0], 2'b00};
  endfunction

  logic [16:0] ceil_w;   // Back-EMF plus current headroom
  logic [15:0] ceil_a;   // After thermal derating
  logic [15:0] ceil_b;   // After over-speed soft limit
  logic [15:0] lim;      // Clipped command

  // Voltage ceiling chain
  always_comb begin
    ceil_w = {1'b0, speed_i} + {1'b0, ihead_i};
    ceil_a = ceil_w[16] ? 16'hffff : ceil_w[15:0];
    // Both temperatures share the same derating law
    ceil_a = sub_sat(ceil_a, derate(ctrl_temp_i, drt_ctrl_i));
    ceil_a = sub_sat(ceil_a, derate(coil_temp_i, drt_coil_i));
    // Output falls further as the speed excess grows
    ceil_b = sub_sat(ceil_a, derate(speed_i, spd_max_i));
    lim    = (cmd_i > ceil_b) ? ceil_b : cmd_i;
    // Regen too high: do not drop below back-EMF, ceiling still wins
    if (bus_volt_i > regen_i && lim < speed_i) begin
      lim = (speed_i > ceil_b) ? ceil_b : speed_i;
    end
    volt_o   = lim;
    derate_o = (ctrl_temp_i > drt_ctrl_i) || (coil_temp_i > drt_coil_i);
  end

endmodule

// file: verilog/motor_protect.sv
// Overview of operation
// - Clip voltage to back-EMF plus current headroom
// - Over-current switches off every gate
// - Over-current latching selectable, non-latching after reset
// - Latched fault holds until flag cleared
// - Non-latching over-current recovers when current drops
// - Over-temperature switches off gates, latch selectable
// - Non-latching over-temperature recovers when temperature drops
// - Near temperature limit enter derate, reduce output
// - Leave derate automatically as temperature falls
// - Derate also on modelled coil temperature
// - Above maximum speed reduce voltage progressively
// - Extreme over-speed shorts all phases together
// - Excess regeneration limits applied voltage
// - Command timeout drops drive into coast, armed flag kept
// - Next valid message ends the timeout
// - Watchdog restarts a stalled controller
// - After restart come up disarmed
`timescale 1ns/10ps
module motor_protect
  import prot_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC,  // Cycles per millisecond
  parameter int unsigned WD_CYCLES = WD_CYC   // Watchdog expiry, cycles
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // Host command events
  input  wire logic        msg_valid_i,
  input  wire logic        arm_i,
  input  wire logic        disarm_i,
  input  wire logic        kick_i,
  // Sensing
  input  wire logic [15:0] cmd_volt_i,
  input  wire logic [15:0] current_i,
  input  wire logic [15:0] ctrl_temp_i,
  input  wire logic [15:0] coil_temp_i,
  input  wire logic [15:0] speed_i,
  input  wire logic [15:0] bus_volt_i,
  // Commutation requests
  input  wire logic [2:0]  pwm_hi_i,
  input  wire logic [2:0]  pwm_lo_i,
  // Power stage and system
  output logic      [2:0]  gate_hi_o,
  output logic      [2:0]  gate_lo_o,
  output logic      [15:0] volt_o,
  output logic             derate_o,
  output logic             drive_o,
  output logic             restart_o,
  output logic             irq_o
);

  // Whole block state
  typedef struct packed {
    logic [1:0]  ctrl;       // Latch selections
    logic [3:0]  status;     // Sticky event flags
    logic [3:0]  mask;       // Interrupt enables
    logic [15:0] oc_thr;     // Over-current threshold
    logic [15:0] ot_thr;     // Over-temperature threshold
    logic [15:0] drt_c;      // Controller derate start
    logic [15:0] drt_m;      // Coil derate start
    logic [15:0] spd_mx;     // Soft speed limit
    logic [15:0] spd_bk;     // Brake speed
    logic [15:0] regen;      // Bus voltage regen limit
    logic [15:0] tout;       // Timeout, ms, zero disables
    logic [15:0] ihead;      // Current headroom as voltage
    sup_state_e  state;      // Supervisor state
    logic        armed;      // Host has armed
    logic        timed_out;  // No message in time
    logic [31:0] ms_cnt;     // Millisecond prescaler
    logic [15:0] tout_cnt;   // Milliseconds since last message
    logic [31:0] wd_cnt;     // Cycles since last kick
    logic [4:0]  rst_cnt;    // Restart pulse remaining
    logic [2:0]  gate_hi;
    logic [2:0]  gate_lo;
    logic [15:0] volt;
    logic        derate;
    logic        drive;
    logic        restart;
    logic        irq;
    logic [31:0] rdata;
  } sup_s;

  sup_s s_q;  // Registered state
  sup_s s_d;  // Next state

  logic [15:0] lim_volt;  // Limited voltage from the chain
  logic        lim_drt;   // Any temperature above its derate start

  volt_limiter u_lim (
    .cmd_i       (cmd_volt_i),
    .speed_i     (speed_i),
    .ctrl_temp_i (ctrl_temp_i),
    .coil_temp_i (coil_temp_i),
    .bus_volt_i  (bus_volt_i),
    .ihead_i     (s_q.ihead),
    .drt_ctrl_i  (s_q.drt_c),
    .drt_coil_i  (s_q.drt_m),
    .spd_max_i   (s_q.spd_mx),
    .regen_i     (s_q.regen),
    .volt_o      (lim_volt),
    .derate_o    (lim_drt)
  );

  logic       oc_trip;   // Current above threshold now
  logic       ot_trip;   // Temperature above threshold now
  logic       fault;     // Gates must be off
  logic       drive;     // Armed and not timed out
  logic       wd_fire;   // Watchdog expiry this cycle
  logic       tout_fire; // Timeout expiry this cycle
  logic [3:0] ev;        // Event set terms
  logic [3:0] clr;       // Write-one-to-clear terms

  // Fault, event and next-state logic
  always_comb begin
    s_d     = s_q;
    oc_trip = current_i > s_q.oc_thr;
    ot_trip = ctrl_temp_i > s_q.ot_thr;
    // A latched flag keeps the stage off even once the cause is gone
    fault   = oc_trip | ot_trip
            | (s_q.ctrl[B_LATCH_OC] & s_q.status[B_OC])
            | (s_q.ctrl[B_LATCH_OT] & s_q.status[B_OT]);
    drive   = s_q.armed & ~s_q.timed_out;
    wd_fire = ~kick_i && (s_q.wd_cnt >= WD_CYCLES - 1);
    tout_fire = 1'b0;

    // Watchdog counts cycles without a kick
    if (kick_i || wd_fire) begin
      s_d.wd_cnt = 32'h0;
    end else begin
      s_d.wd_cnt = s_q.wd_cnt + 32'h1;
    end

    // Restart pulse
    if (wd_fire) begin
      s_d.rst_cnt = RST_PULSE;
    end else if (s_q.rst_cnt != 5'h0) begin
      s_d.rst_cnt = s_q.rst_cnt - 5'h1;
    end
    s_d.restart = wd_fire || (s_q.rst_cnt > 5'h1);

    // Millisecond prescaler and message timeout
    if (msg_valid_i) begin
      s_d.ms_cnt    = 32'h0;
      s_d.tout_cnt  = 16'h0;
      s_d.timed_out = 1'b0;
    end else if (s_q.ms_cnt >= MS_CYCLES - 1) begin
      s_d.ms_cnt = 32'h0;
      if (s_q.tout_cnt != 16'hffff) begin
        s_d.tout_cnt = s_q.tout_cnt + 16'h1;
      end
    end else begin
      s_d.ms_cnt = s_q.ms_cnt + 32'h1;
    end
    // Zero timeout disables the check
    if (!msg_valid_i && s_q.tout != 16'h0 && s_q.tout_cnt >= s_q.tout && !s_q.timed_out) begin
      s_d.timed_out = 1'b1;
      tout_fire     = 1'b1;
    end

    // Arming, explicit disarm; restart forces the startup state
    if (arm_i) begin
      s_d.armed = 1'b1;
    end
    if (disarm_i || wd_fire) begin
      s_d.armed = 1'b0;
    end
    if (wd_fire) begin
      s_d.timed_out = 1'b0;
      s_d.tout_cnt  = 16'h0;
    end

    // Register writes
    clr = 4'h0;
    if (wr_i) begin
      unique case (addr_i)
        A_CTRL:   s_d.ctrl   = wdata_i[1:0];
        A_STATUS: clr        = wdata_i[3:0];
        A_MASK:   s_d.mask   = wdata_i[3:0];
        A_OC_THR: s_d.oc_thr = wdata_i[15:0];
        A_OT_THR: s_d.ot_thr = wdata_i[15:0];
        A_DRT_C:  s_d.drt_c  = wdata_i[15:0];
        A_DRT_M:  s_d.drt_m  = wdata_i[15:0];
        A_SPD_MX: s_d.spd_mx = wdata_i[15:0];
        A_SPD_BK: s_d.spd_bk = wdata_i[15:0];
        A_REGEN:  s_d.regen  = wdata_i[15:0];
        A_TOUT:   s_d.tout   = wdata_i[15:0];
        A_IHEAD:  s_d.ihead  = wdata_i[15:0];
        default:  clr        = 4'h0;  // Unmapped writes are ignored
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    ev         = 4'h0;
    ev[B_OC]   = oc_trip;
    ev[B_OT]   = ot_trip;
    ev[B_TOUT] = tout_fire;
    ev[B_WD]   = wd_fire;
    s_d.status = (s_q.status & ~clr) | ev;
    s_d.irq    = |(s_d.status & s_q.mask);

    // Supervisor state, off first, then faults
    if (!drive) begin
      s_d.state = ST_OFF;
    end else if (fault) begin
      s_d.state = ST_FAULT;
    end else if (speed_i > s_q.spd_bk) begin
      s_d.state = ST_BRAKE;
    end else if (lim_drt) begin
      s_d.state = ST_DERATE;
    end else begin
      s_d.state = ST_RUN;
    end

    // Gate and voltage outputs per state
    unique case (s_d.state)
      ST_OFF: begin
        // Coast: every transistor open
        s_d.gate_hi = 3'h0;
        s_d.gate_lo = 3'h0;
        s_d.volt    = 16'h0;
      end
      ST_FAULT: begin
        // Reactive shutdown; clears itself when not latched
        s_d.gate_hi = 3'h0;
        s_d.gate_lo = 3'h0;
        s_d.volt    = 16'h0;
      end
      ST_BRAKE: begin
        // All low sides on shorts the phases together
        s_d.gate_hi = 3'h0;
        s_d.gate_lo = 3'h7;
        s_d.volt    = 16'h0;
      end
      default: begin
        // Run and derate pass commutation, voltage already limited
        s_d.gate_hi = pwm_hi_i;
        s_d.gate_lo = pwm_lo_i;
        s_d.volt    = lim_volt;
      end
    endcase
    s_d.derate = (s_d.state == ST_DERATE);
    s_d.drive  = drive;

    // Read data stands for exactly the cycle after the strobe
    s_d.rdata = 32'h0;
    if (rd_i) begin
      unique case (addr_i)
        A_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
        A_STATUS: s_d.rdata = {28'h0, s_q.status};
        A_MASK:   s_d.rdata = {28'h0, s_q.mask};
        A_STATE:  s_d.rdata = {24'h0, s_q.timed_out, s_q.armed, 1'b0, s_q.state};
        A_OC_THR: s_d.rdata = {16'h0, s_q.oc_thr};
        A_OT_THR: s_d.rdata = {16'h0, s_q.ot_thr};
        A_DRT_C:  s_d.rdata = {16'h0, s_q.drt_c};
        A_DRT_M:  s_d.rdata = {16'h0, s_q.drt_m};
        A_SPD_MX: s_d.rdata = {16'h0, s_q.spd_mx};
        A_SPD_BK: s_d.rdata = {16'h0, s_q.spd_bk};
        A_REGEN:  s_d.rdata = {16'h0, s_q.regen};
        A_TOUT:   s_d.rdata = {16'h0, s_q.tout};
        A_IHEAD:  s_d.rdata = {16'h0, s_q.ihead};
        default:  s_d.rdata = 32'h0;  // Unmapped reads return zero
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q           <= '0;
      s_q.ctrl      <= R_CTRL;
      s_q.mask      <= R_MASK;
      s_q.oc_thr    <= R_OC_THR;
      s_q.ot_thr    <= R_OT_THR;
      s_q.drt_c     <= R_DRT_C;
      s_q.drt_m     <= R_DRT_M;
      s_q.spd_mx    <= R_SPD_MX;
      s_q.spd_bk    <= R_SPD_BK;
      s_q.regen     <= R_REGEN;
      s_q.tout      <= R_TOUT;
      s_q.ihead     <= R_IHEAD;
      s_q.state     <= ST_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign gate_hi_o = s_q.gate_hi;
  assign gate_lo_o = s_q.gate_lo;
  assign volt_o    = s_q.volt;
  assign derate_o  = s_q.derate;
  assign drive_o   = s_q.drive;
  assign restart_o = s_q.restart;
  assign irq_o     = s_q.irq;
  assign rdata_o   = s_q.rdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  oc_gates_off_a: assert property (
      oc_trip |=> (gate_hi_o == 3'h0) && (gate_lo_o == 3'h0))
    else $error("over-current did not open all gates");

  ot_gates_off_a: assert property (
      ot_trip |=> (gate_hi_o == 3'h0) && (gate_lo_o == 3'h0))
    else $error("over-temperature did not open all gates");

  latch_hold_a: assert property (
      (s_q.ctrl[B_LATCH_OC] && s_q.status[B_OC]) |=> gate_hi_o == 3'h0)
    else $error("latched over-current let gates drive");

  nonlatch_resume_a: assert property (
      (s_q.ctrl == 2'h0 && drive && !oc_trip && !ot_trip && speed_i <= s_q.spd_bk)
      |=> gate_hi_o == $past(pwm_hi_i))
    else $error("non-latching fault did not recover");

  derate_enter_a: assert property (
      (drive && !fault && speed_i <= s_q.spd_bk && lim_drt)
      |=> derate_o && s_q.state == ST_DERATE)
    else $error("derate state not entered");

  brake_short_a: assert property (
      s_q.state == ST_BRAKE |-> gate_lo_o == 3'h7 && gate_hi_o == 3'h0)
    else $error("brake did not short phases");

  volt_ceiling_a: assert property (
      ##1 {1'b0, volt_o} <= {1'b0, $past(speed_i)} + {1'b0, $past(s_q.ihead)})
    else $error("voltage above headroom ceiling");

  // Drive output lags the flag by one cycle, gates open in that same cycle
  tout_coast_a: assert property (
      $rose(s_q.timed_out) |=> !drive_o && gate_hi_o == 3'h0 && gate_lo_o == 3'h0)
    else $error("timeout did not coast");

  msg_resume_a: assert property (
      (s_q.timed_out && msg_valid_i) |=> !s_q.timed_out)
    else $error("message did not end timeout");

  wd_restart_a: assert property (
      (s_q.wd_cnt >= WD_CYCLES - 1 && !kick_i)
      |=> restart_o && !s_q.armed && s_q.status[B_WD])
    else $error("watchdog did not restart");

endmodule

// file: test/host_link_model.sv
`timescale 1ns/10ps
module host_link_model
  import prot_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Bench control
  input  wire logic msg_en_i,
  // Host command events
  output logic      msg_valid_o,
  output logic      arm_o,
  output logic      disarm_o
);
  logic [3:0] cnt_q;  // Message period counter

  // One valid message every 16 cycles while enabled
  // Host must beat the timeout, so the period stays short
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q       <= 4'h0;
      msg_valid_o <= 1'b0;
    end else begin
      cnt_q       <= cnt_q + 4'h1;
      msg_valid_o <= msg_en_i && (cnt_q == 4'hf);
    end
  end

  // Idle command lines at time zero
  initial begin
    arm_o    = 1'b0;
    disarm_o = 1'b0;
  end

  // Arming pulse, repeated by the host after every restart
  task automatic send_arm();
    @(posedge clk_i);
    arm_o <= 1'b1;
    @(posedge clk_i);
    arm_o <= 1'b0;
  endtask

  // Disarming pulse
  task automatic send_disarm();
    @(posedge clk_i);
    disarm_o <= 1'b1;
    @(posedge clk_i);
    disarm_o <= 1'b0;
  endtask
endmodule

// file: test/motor_protect_tb_top.sv
`timescale 1ns/10ps
module motor_protect_tb_top
  import prot_pkg::*;
();
  logic        clk_i = 1'b0;  // 50 MHz clock
  logic        rstn_i, wr_i, rd_i, kick_en, msg_en;
  logic        kick_i = 1'b0;  // Heartbeat, known low before the first edge
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o;
  logic [15:0] cmd_volt_i, current_i, ctrl_temp_i, coil_temp_i, speed_i, bus_volt_i, volt_o;
  logic [2:0]  pwm_hi_i, gate_hi_o, gate_lo_o;
  logic        derate_o, drive_o, restart_o, irq_o;
  wire         msg_valid_i, arm_i, disarm_i;
  int          n_errors = 0;
  int          checks = 0;
  int          i, cnt;

  always #10 clk_i = ~clk_i;

  // Device under test, short counts keep the run brief
  motor_protect #(.MS_CYCLES(4), .WD_CYCLES(64)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .msg_valid_i(msg_valid_i), .arm_i(arm_i),
    .disarm_i(disarm_i), .kick_i(kick_i), .cmd_volt_i(cmd_volt_i), .current_i(current_i),
    .ctrl_temp_i(ctrl_temp_i), .coil_temp_i(coil_temp_i), .speed_i(speed_i),
    .bus_volt_i(bus_volt_i), .pwm_hi_i(pwm_hi_i), .pwm_lo_i(~pwm_hi_i),
    .gate_hi_o(gate_hi_o), .gate_lo_o(gate_lo_o), .volt_o(volt_o), .derate_o(derate_o),
    .drive_o(drive_o), .restart_o(restart_o), .irq_o(irq_o));

  // Host side of the command link
  host_link_model host (
    .clk_i(clk_i), .rstn_i(rstn_i), .msg_en_i(msg_en), .msg_valid_o(msg_valid_i),
    .arm_o(arm_i), .disarm_o(disarm_i));

  // Heartbeat pulse every other cycle while enabled
  always @(posedge clk_i) kick_i <= kick_en & ~kick_i;

  // Final verdict, reached from the tests and the hang guard alike
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Step n edges and let updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Register value compare
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Output value compare
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // Read, data taken in the cycle after the strobe only
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk32(rdata_o, e);
  endtask

  // Sensor inputs and a fresh random commutation pattern
  task automatic drv(input logic [15:0] cur, tc, tl, spd, bus, cmd);
    @(posedge clk_i);
    current_i   <= cur;
    ctrl_temp_i <= tc;
    coil_temp_i <= tl;
    speed_i     <= spd;
    bus_volt_i  <= bus;
    cmd_volt_i  <= cmd;
    pwm_hi_i    <= 3'($urandom);
    tick(2);
  endtask

  // Gates against expectation, normal drive when g is set
  task automatic gates(input logic g, input logic [2:0] h, input logic [2:0] l);
    if (g) chk16({10'h0, gate_hi_o, gate_lo_o}, {10'h0, pwm_hi_i, ~pwm_hi_i});
    else chk16({10'h0, gate_hi_o, gate_lo_o}, {10'h0, h, l});
  endtask

  // Expected voltage with cool temperatures: headroom and over-speed cut
  function automatic logic [15:0] exp_v(input logic [15:0] c, input logic [15:0] s);
    int m;
    m = s + 32'h200;
    if (s > R_SPD_MX) m = m - 4 * (s - R_SPD_MX);
    if (m < 0) m = 0;
    if (m > 32'hffff) m = 32'hffff;
    return (c < m) ? c : m[15:0];
  endfunction

  // Hang guard
  initial begin
    #1_000_000;
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    {rstn_i, wr_i, rd_i, addr_i, wdata_i, pwm_hi_i} = '0;
    {cmd_volt_i, current_i, ctrl_temp_i, coil_temp_i, speed_i, bus_volt_i} = '0;
    kick_en = 1'b1;
    msg_en  = 1'b1;
    cnt     = $urandom(32'h2bc7f2a4);
    tick(16);
    rstn_i <= 1'b1;
    tick(2);
    rdc(A_CTRL, {30'h0, R_CTRL});
    rdc(A_MASK, 32'h0);
    rdc(A_OC_THR, {16'h0, R_OC_THR});
    rdc(A_TOUT, {16'h0, R_TOUT});
    rdc(8'hfc, 32'h0);
    rdc(A_STATE, 32'h01);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0400, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h0);
    $display("test reset done");
    host.send_arm();
    tick(3);
    chk16({15'h0, drive_o}, 16'h1);
    for (i = 0; i < 20; i++) begin
      drv(16'($urandom % 16'h0b00), 16'h0100, 16'h0100, 16'($urandom % 16'h0f00),
          16'h0400, 16'($urandom));
      chk16(volt_o, exp_v(cmd_volt_i, speed_i));
      gates(1'b1, 3'h0, 3'h0);
    end
    for (i = 0; i < 3; i++) begin
      drv(16'h0100, 16'h0100, 16'h0100, 16'h1080 + 16'(i * 16'h0180), 16'h0400, 16'hffff);
      chk16(volt_o, exp_v(16'hffff, speed_i));
    end
    drv(16'h0100, 16'h0100, 16'h0100, 16'h1900, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h7);
    rdc(A_STATE, 32'h50);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0f00, 16'h0000);
    chk16(volt_o, 16'h0800);
    $display("test voltage done");
    drv(16'h0100, 16'h0650, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    chk16({derate_o, volt_o[14:0]}, 16'h88c0);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    chk16({15'h0, derate_o}, 16'h0);
    drv(16'h0100, 16'h0100, 16'h0950, 16'h0800, 16'h0400, 16'hffff);
    chk16({derate_o, volt_o[14:0]}, 16'h88c0);
    // Huge coil excess must cut the voltage to zero, not wrap to a small cut
    drv(16'h0100, 16'h0100, 16'h4910, 16'h0800, 16'h0400, 16'hffff);
    chk16({derate_o, volt_o[14:0]}, 16'h8000);
    $display("test derate done");
    wr(A_MASK, 32'h1);
    drv(16'h0d00, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h0);
    tick(1);
    chk16({15'h0, irq_o}, 16'h1);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b1, 3'h0, 3'h0);
    rdc(A_STATUS, 32'h1);
    wr(A_STATUS, 32'h1);
    rdc(A_STATUS, 32'h0);
    tick(1);
    chk16({15'h0, irq_o}, 16'h0);
    wr(A_CTRL, 32'h3);
    drv(16'h0d00, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h0);
    wr(A_STATUS, 32'h1);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b1, 3'h0, 3'h0);
    drv(16'h0100, 16'h0800, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h0);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b0, 3'h0, 3'h0);
    wr(A_STATUS, 32'h2);
    wr(A_CTRL, 32'h0);
    drv(16'h0100, 16'h0800, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    rdc(A_STATUS, 32'h2);
    drv(16'h0100, 16'h0100, 16'h0100, 16'h0800, 16'h0400, 16'hffff);
    gates(1'b1, 3'h0, 3'h0);
    wr(A_STATUS, 32'h2);
    $display("test faults done");
    wr(A_TOUT, 32'h1);
    msg_en <= 1'b0;
    for (i = 0; i < 60 && drive_o !== 1'b0; i++) tick(1);
    chk16({15'h0, drive_o}, 16'h0);
    tick(2);
    gates(1'b0, 3'h0, 3'h0);
    rdc(A_STATUS, 32'h4);
    wr(A_TOUT, {16'h0, R_TOUT});
    msg_en <= 1'b1;
    for (i = 0; i < 60 && drive_o !== 1'b1; i++) tick(1);
    chk16({15'h0, drive_o}, 16'h1);
    wr(A_STATUS, 32'h4);
    host.send_disarm();
    tick(3);
    chk16({15'h0, drive_o}, 16'h0);
    host.send_arm();
    $display("test timeout done");
    kick_en <= 1'b0;
    for (i = 0; i < 200 && restart_o !== 1'b1; i++) tick(1);
    for (cnt = 0; cnt < 40 && restart_o === 1'b1; cnt++) tick(1);
    chk16(16'(cnt), {11'h0, RST_PULSE});
    kick_en <= 1'b1;
    chk16({15'h0, drive_o}, 16'h0);
    rdc(A_STATUS, 32'h8);
    host.send_arm();
    tick(3);
    chk16({15'h0, drive_o}, 16'h1);
    $display("test watchdog done");
    stop_test();
  end
endmodule
